// ### hw/output_channel_source_divider.sv
// Channel six clock source selection, divider, format and leg control.
`timescale 1ns/100ps
`default_nettype none

module output_channel_source_divider (
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST,
  // Register port.
  input wire ch6_clk_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // Source clocks and doubler state, all from outside this clock domain.
  input wire logic SYNTH_A_CLK,
  input wire logic SYNTH_B_CLK,
  input wire logic PRI_REF_CLK,
  input wire logic PRI_REF_X2_CLK,
  input wire logic SEC_REF_CLK,
  input wire logic SEC_REF_X2_CLK,
  input wire logic DOUBLER_EN,
  // Output stage.
  output ch6_clk_pkg::drive_t CH_DRIVE,
  output ch6_clk_pkg::leg_t CH_TRUE,
  output ch6_clk_pkg::leg_t CH_COMP
);
  import ch6_clk_pkg::*;

  // Bit order of the synchroniser vector.
  localparam int PIN_A = 0;
  localparam int PIN_B = 1;
  localparam int PIN_PRI = 2;
  localparam int PIN_PRI2 = 3;
  localparam int PIN_SEC = 4;
  localparam int PIN_SEC2 = 5;
  localparam int PIN_DBL = 6;

  ctl_t ctl;
  ctl_t next_ctl;
  logic [7:0] div_code;
  logic [7:0] next_div_code;
  logic [7:0] next_rdata;
  logic [6:0] pin_meta;
  logic [6:0] pin_sync;
  logic synth_level;
  logic ref_level;
  logic div_level;
  logic ch_clk;
  drive_t next_drive;
  leg_t next_true;
  leg_t next_comp;

  // Decode of one single-ended leg; used for both legs.
  function automatic leg_t leg_drive(input leg_mode_t mode, input logic clk);
    leg_t r;
    r = '{level: 1'b0, oe_n: 1'b1};
    unique case (mode)
      LEG_TRISTATE: r = '{level: 1'b0, oe_n: 1'b1};
      LEG_LOW: r = '{level: 1'b0, oe_n: 1'b0};
      LEG_INVERTED: r = '{level: ~clk, oe_n: 1'b0};
      LEG_NORMAL: r = '{level: clk, oe_n: 1'b0};
    endcase
    return r;
  endfunction : leg_drive

  // Register writes and reads; a read answers one cycle later and holds until the next read.
  always_comb begin
    next_ctl = ctl;
    next_div_code = div_code;
    next_rdata = REG_RDATA;
    if (REG_REQ.wr && REG_REQ.addr == OUTPUT6_CONTROL_ADDR) begin
      next_ctl = ctl_t'(REG_REQ.wdata);
    end
    if (REG_REQ.wr && REG_REQ.addr == OUTPUT6_DIVIDER_ADDR) begin
      next_div_code = REG_REQ.wdata;
    end
    if (REG_REQ.rd) begin
      if (REG_REQ.addr == OUTPUT6_CONTROL_ADDR) begin
        next_rdata = ctl;
      end else if (REG_REQ.addr == OUTPUT6_DIVIDER_ADDR) begin
        next_rdata = div_code;
      end else begin
        next_rdata = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ctl <= CTL_RESET;
      div_code <= OUTPUT6_DIVIDER_RESET;
      REG_RDATA <= UNMAPPED_READ;
    end else begin
      ctl <= next_ctl;
      div_code <= next_div_code;
      REG_RDATA <= next_rdata;
    end
  end

  // Two-stage synchroniser; only the second stage is read by logic.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      pin_meta <= 7'h00;
      pin_sync <= 7'h00;
    end else begin
      pin_meta <= {DOUBLER_EN, SEC_REF_X2_CLK, SEC_REF_CLK, PRI_REF_X2_CLK, PRI_REF_CLK, SYNTH_B_CLK, SYNTH_A_CLK};
      pin_sync <= pin_meta;
    end
  end

  // Source selection; references never see the divider.
  always_comb begin
    synth_level = (ctl.ch_source_select == SRC_SYNTH_B) ? pin_sync[PIN_B] : pin_sync[PIN_A];
    if (ctl.ch_source_select == SRC_PRI_REF) begin
      ref_level = pin_sync[PIN_DBL] ? pin_sync[PIN_PRI2] : pin_sync[PIN_PRI];
    end else begin
      ref_level = pin_sync[PIN_DBL] ? pin_sync[PIN_SEC2] : pin_sync[PIN_SEC];
    end
    if (ctl.ch_source_select == SRC_PRI_REF || ctl.ch_source_select == SRC_SEC_REF) begin
      ch_clk = ref_level;
    end else begin
      ch_clk = div_level;
    end
  end

  // The divider sees the synthesizer mux only, so under a reference choice it keeps dividing synthesizer A, unused.
  ratio_divider u_divider (
    .clk(CORE_CLK),
    .rst(RST),
    .src_level(synth_level),
    .ratio_code(div_code),
    .div_level(div_level)
  );

  // Format decode and leg drive; a disabled channel floats both legs.
  always_comb begin
    next_drive = '{diff_en: 1'b0, hcsl_en: 1'b0, cmos_en: 1'b0};
    next_true = '{level: 1'b0, oe_n: 1'b1};
    next_comp = '{level: 1'b0, oe_n: 1'b1};
    unique case (ctl.fmt)
      FMT_OFF: begin
        next_drive = '{diff_en: 1'b0, hcsl_en: 1'b0, cmos_en: 1'b0};
      end
      FMT_AC_DIFF: begin
        next_drive.diff_en = 1'b1;
        next_true = '{level: ch_clk, oe_n: 1'b0};
        next_comp = '{level: ~ch_clk, oe_n: 1'b0};
      end
      FMT_HCSL: begin
        next_drive.hcsl_en = 1'b1;
        next_true = '{level: ch_clk, oe_n: 1'b0};
        next_comp = '{level: ~ch_clk, oe_n: 1'b0};
      end
      FMT_CMOS: begin
        next_drive.cmos_en = 1'b1;
        next_true = leg_drive(ctl.ch_true_leg_mode, ch_clk);
        next_comp = leg_drive(ctl.ch_comp_leg_mode, ch_clk);
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      CH_DRIVE <= '{diff_en: 1'b0, hcsl_en: 1'b0, cmos_en: 1'b0};
      CH_TRUE <= '{level: 1'b0, oe_n: 1'b1};
      CH_COMP <= '{level: 1'b0, oe_n: 1'b1};
    end else begin
      CH_DRIVE <= next_drive;
      CH_TRUE <= next_true;
      CH_COMP <= next_comp;
    end
  end

  // A CMOS normal leg shows the channel clock one cycle later.
  sequence cmos_normal_s;
    ctl.fmt == FMT_CMOS && ctl.ch_true_leg_mode == LEG_NORMAL;
  endsequence

  synth_route_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cmos_normal_s and (ctl.ch_source_select == SRC_SYNTH_A) |=> CH_TRUE.level == $past(div_level))
    else $error("synthesizer source not routed");
  synth_b_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.ch_source_select == SRC_SYNTH_B |-> synth_level == pin_sync[PIN_B])
    else $error("second synthesizer not fed to divider");
  doubler_pick_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cmos_normal_s and (ctl.ch_source_select == SRC_PRI_REF && pin_sync[PIN_DBL])
    |=> CH_TRUE.level == $past(pin_sync[PIN_PRI2])) else $error("doubled reference not used");
  ref_bypass_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cmos_normal_s and (ctl.ch_source_select == SRC_SEC_REF && !pin_sync[PIN_DBL])
    |=> CH_TRUE.level == $past(pin_sync[PIN_SEC])) else $error("reference did not bypass divider");
  // The raw primary reference must also skip the divider, whatever code is loaded.
  pri_bypass_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    cmos_normal_s and (ctl.ch_source_select == SRC_PRI_REF && !pin_sync[PIN_DBL])
    |=> CH_TRUE.level == $past(pin_sync[PIN_PRI])) else $error("primary reference not passed");
  fmt_off_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_OFF |=> CH_TRUE.oe_n && CH_COMP.oe_n && CH_DRIVE == 3'h0)
    else $error("disabled output still driven");
  ac_pair_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_AC_DIFF |=> CH_DRIVE.diff_en && !CH_TRUE.oe_n && CH_TRUE.level != CH_COMP.level)
    else $error("AC differential legs wrong");
  diff_pair_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_HCSL |=> CH_DRIVE.hcsl_en && CH_TRUE.level != CH_COMP.level)
    else $error("differential legs not complementary");
  leg_tri_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_CMOS && ctl.ch_true_leg_mode == LEG_TRISTATE |=> CH_TRUE.oe_n)
    else $error("tri-state leg driven");
  leg_low_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_CMOS && ctl.ch_comp_leg_mode == LEG_LOW |=> !CH_COMP.oe_n && !CH_COMP.level)
    else $error("low leg not driven low");
  leg_inv_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ctl.fmt == FMT_CMOS && ctl.ch_comp_leg_mode == LEG_INVERTED |=> CH_COMP.level == !$past(ch_clk))
    else $error("inverted leg wrong polarity");

endmodule : output_channel_source_divider

`default_nettype wire

// ### hw/ch6_clk_pkg.sv
// Constants, field layouts and types shared by the channel six clock control block.
package ch6_clk_pkg;

  // Register offsets on the register port.
  localparam logic [7:0] OUTPUT6_CONTROL_ADDR = 8'h29;
  localparam logic [7:0] OUTPUT6_DIVIDER_ADDR = 8'h2a;

  // Field positions inside output6_control.
  localparam int SRC_SEL_POS = 6;
  localparam int FMT_SEL_POS = 4;
  localparam int TRUE_MODE_POS = 2;
  localparam int COMP_MODE_POS = 0;

  // Reset values of the fields and of the divider.
  localparam logic [1:0] SRC_SEL_RESET = 2'h0;
  localparam logic [1:0] FMT_SEL_RESET = 2'h1;
  localparam logic [1:0] TRUE_MODE_RESET = 2'h2;
  localparam logic [1:0] COMP_MODE_RESET = 2'h0;
  localparam logic [7:0] OUTPUT6_DIVIDER_RESET = 8'h05;

  // Value returned for an unmapped read.
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;

  // Clock source codes.
  typedef enum logic [1:0] {
    SRC_SYNTH_A = 2'h0,
    SRC_SYNTH_B = 2'h1,
    SRC_PRI_REF = 2'h2,
    SRC_SEC_REF = 2'h3
  } src_sel_t;

  // Output format codes.
  typedef enum logic [1:0] {
    FMT_OFF = 2'h0,
    FMT_AC_DIFF = 2'h1,
    FMT_HCSL = 2'h2,
    FMT_CMOS = 2'h3
  } fmt_sel_t;

  // Single-ended leg codes.
  typedef enum logic [1:0] {
    LEG_TRISTATE = 2'h0,
    LEG_LOW = 2'h1,
    LEG_INVERTED = 2'h2,
    LEG_NORMAL = 2'h3
  } leg_mode_t;

  // Layout of output6_control.
  typedef struct packed {
    src_sel_t ch_source_select;
    fmt_sel_t fmt;
    leg_mode_t ch_true_leg_mode;
    leg_mode_t ch_comp_leg_mode;
  } ctl_t;

  localparam ctl_t CTL_RESET = '{src_sel_t'(SRC_SEL_RESET), fmt_sel_t'(FMT_SEL_RESET),
                                 leg_mode_t'(TRUE_MODE_RESET), leg_mode_t'(COMP_MODE_RESET)};

  // One output leg: level and active-low output enable.
  typedef struct packed {
    logic level;
    logic oe_n;
  } leg_t;

  // Driver format enables for the analog stage.
  typedef struct packed {
    logic diff_en;
    logic hcsl_en;
    logic cmos_en;
  } drive_t;

  // Register read and write port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : ch6_clk_pkg

// ### hw/ratio_divider.sv
// Programmable divide-by-(code plus one) counter for a sampled source clock.
`timescale 1ns/100ps
`default_nettype none

module ratio_divider (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Source level and ratio code.
  input wire logic src_level,
  input wire logic [7:0] ratio_code,
  // Divided level.
  output logic div_level
);
  import ch6_clk_pkg::*;

  logic prev;
  logic [7:0] cnt;
  logic next_prev;
  logic [7:0] next_cnt;
  logic next_div_level;
  logic rise;
  logic [8:0] high_len;

  // Count source rising edges; the high phase is the first half of each period, rounded down to whole source periods.
  always_comb begin
    rise = src_level & ~prev;
    next_prev = src_level;
    next_cnt = cnt;
    high_len = ({1'b0, ratio_code} + 9'h001) >> 1;
    if (rise) begin
      next_cnt = (cnt >= ratio_code) ? 8'h00 : cnt + 8'h01;
    end
    // Ratio one passes the source; the counter cannot produce a full-rate clock.
    if (ratio_code == 8'h00) begin
      next_div_level = src_level;
    end else begin
      next_div_level = ({1'b0, next_cnt} < high_len);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'b0;
      cnt <= 8'h00;
      div_level <= 1'b0;
    end else begin
      prev <= next_prev;
      cnt <= next_cnt;
      div_level <= next_div_level;
    end
  end

  sequence wrap_edge_s;
    rise && cnt >= ratio_code;
  endsequence

  sequence count_edge_s;
    rise && cnt < ratio_code;
  endsequence

  property wrap_p;
    @(posedge clk) disable iff (rst) wrap_edge_s |=> cnt == 8'h00;
  endproperty

  property step_p;
    @(posedge clk) disable iff (rst) count_edge_s |=> cnt == $past(cnt) + 8'h01;
  endproperty

  period_wrap_a: assert property (wrap_p) else $error("divider did not wrap at ratio");
  period_step_a: assert property (step_p) else $error("divider skipped a source edge");
  count_hold_a: assert property (@(posedge clk) disable iff (rst)
    !rise && $stable(ratio_code) |=> $stable(cnt)) else $error("divider moved without edge");
  phase_start_a: assert property (@(posedge clk) disable iff (rst)
    (ratio_code != 8'h00 && $stable(ratio_code)) and wrap_edge_s |=> div_level)
    else $error("period did not start high");

endmodule : ratio_divider

`default_nettype wire

// ### tb/clk_receiver.sv
// Board receiver model that times the channel clock seen on one output leg.
`timescale 1ns/100ps
`default_nettype none

module clk_receiver (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Observed leg.
  input wire ch6_clk_pkg::leg_t leg,
  // Last period, last high time and rising edge count, in core cycles.
  output var int period,
  output var int high,
  output var int edges
);
  import ch6_clk_pkg::*;
  int cnt;
  logic last;
  logic lvl;

  // A released leg reads as low, since the board load pulls it down.
  assign lvl = leg.level & ~leg.oe_n;

  // Times rising to rising and rising to falling on the core grid.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      last <= 1'b0;
      period <= 0;
      high <= 0;
      edges <= 0;
    end else begin
      last <= lvl;
      cnt <= cnt + 1;
      if (lvl && !last) begin
        period <= cnt;
        cnt <= 1;
        edges <= edges + 1;
      end
      if (!lvl && last) high <= cnt;
    end
  end
endmodule : clk_receiver

`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the channel six source, divider and leg control.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import ch6_clk_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  reg_req_t REG_REQ = '0;
  logic [7:0] REG_RDATA;
  logic [5:0] src = 6'h00;
  logic DOUBLER_EN = 1'b0;
  drive_t CH_DRIVE;
  leg_t CH_TRUE;
  leg_t CH_COMP;
  int period, high, edges, cyc = 0, error_cnt = 0, checks = 0;
  // Half periods of A, B, primary, primary doubled, secondary, secondary doubled; all distinct.
  int half [6] = '{7, 4, 6, 3, 10, 5};
  logic [7:0] d;
  logic [7:0] a;

  always #2.5 CORE_CLK = ~CORE_CLK;

  // Source clocks on the core grid, so every measured time is an exact count.
  always @(posedge CORE_CLK) begin
    cyc <= cyc + 1;
    for (int i = 0; i < 6; i++) src[i] <= ((cyc / half[i]) % 2) != 0;
  end

  output_channel_source_divider DUT (.CORE_CLK(CORE_CLK), .RST(RST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
    .SYNTH_A_CLK(src[0]), .SYNTH_B_CLK(src[1]), .PRI_REF_CLK(src[2]), .PRI_REF_X2_CLK(src[3]),
    .SEC_REF_CLK(src[4]), .SEC_REF_X2_CLK(src[5]), .DOUBLER_EN(DOUBLER_EN), .CH_DRIVE(CH_DRIVE),
    .CH_TRUE(CH_TRUE), .CH_COMP(CH_COMP));
  clk_receiver RX (.clk(CORE_CLK), .rst(RST), .leg(CH_TRUE), .period(period), .high(high), .edges(edges));

  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
    @(posedge CORE_CLK);
    REG_REQ <= '{1'b1, 1'b0, ad, dt};
    @(posedge CORE_CLK);
    REG_REQ <= '0;
  endtask : wr

  // The answer is registered at the strobe edge, so it is read just after it.
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    @(posedge CORE_CLK);
    REG_REQ <= '{1'b0, 1'b1, ad, 8'h00};
    @(posedge CORE_CLK);
    REG_REQ <= '0;
    #1 chk({8'h00, REG_RDATA}, {8'h00, e});
  endtask : rd

  function automatic leg_t exp_leg(input logic [1:0] m, input logic l);
    case (m)
      2'h0: return '{1'b0, 1'b1};
      2'h1: return '{1'b0, 1'b0};
      2'h2: return '{~l, 1'b0};
      default: return '{l, 1'b0};
    endcase
  endfunction : exp_leg

  // One leg set to code m, the other left normal as the reference level.
  task automatic legs(input logic [7:0] c, input logic [1:0] m, input logic side);
    wr(8'h29, c);
    repeat (4) @(posedge CORE_CLK);
    repeat (20) begin
      @(posedge CORE_CLK);
      #1 chk({14'h0, side ? CH_COMP : CH_TRUE}, {14'h0, exp_leg(m, side ? CH_TRUE.level : CH_COMP.level)});
    end
  endtask : legs

  // Three fresh edges let any switching glitch pass before the last period is taken.
  task automatic measure(input logic [1:0] s, input logic dbl, input logic [7:0] code);
    int h;
    int n;
    int e0;
    h = half[s < 2 ? s : 2 * s - 2 + dbl];
    n = s < 2 ? code + 1 : 1;
    @(posedge CORE_CLK);
    DOUBLER_EN <= dbl;
    wr(8'h2a, code);
    wr(8'h29, {s, 6'h3f});
    // A source switch can fake a divider edge a few cycles on; start counting only after it.
    repeat (8) @(posedge CORE_CLK);
    e0 = edges;
    for (int i = 0; i < 9000 && edges < e0 + 3; i++) @(posedge CORE_CLK);
    if (edges < e0 + 3) begin
      error_cnt++;
      test_done();
    end else begin
      #1 chk(period[15:0], 16'(2 * h * n));
      chk(high[15:0], 16'(n == 1 ? h : n / 2 * 2 * h));
    end
  endtask : measure

  initial begin
    void'($urandom(82079));
    repeat (6) @(posedge CORE_CLK);
    RST <= 1'b0;
    rd(8'h29, 8'h18);
    rd(8'h2a, 8'h05);
    // Random traffic, with an unmapped write and read that must not disturb anything.
    repeat (8) begin
      d = 8'($urandom);
      a = 8'($urandom);
      if (a == 8'h29 || a == 8'h2a) a = 8'h00;
      wr(8'h2a, d);
      wr(8'h29, ~d);
      wr(a, 8'h5a);
      rd(8'h2a, d);
      rd(8'h29, ~d);
      rd(a, 8'h00);
    end
    wr(8'h2a, 8'h00);
    // Every format, checked over enough cycles to see both clock levels.
    for (int f = 0; f < 4; f++) begin
      wr(8'h29, {2'h0, 2'(f), 4'hf});
      repeat (4) @(posedge CORE_CLK);
      repeat (20) begin
        @(posedge CORE_CLK);
        #1 chk({13'h0, CH_DRIVE}, {13'h0, f == 0 ? 3'b000 : 3'(4 >> (f - 1))});
        chk({13'h0, CH_TRUE.oe_n, CH_COMP}, {13'h0, f == 0, f == 0 ? 2'b01 : {CH_TRUE.level ^ (f != 3), 1'b0}});
      end
    end
    for (int m = 0; m < 4; m++) begin
      legs({4'h3, 2'(m), 2'h3}, 2'(m), 1'b0);
      legs({4'h3, 2'h3, 2'(m)}, 2'(m), 1'b1);
    end
    for (int s = 0; s < 4; s++)
      for (int b = 0; b < 2; b++) measure(2'(s), 1'(b), 8'($urandom % 16));
    measure(2'h0, 1'b0, 8'h00);
    measure(2'h1, 1'b0, 8'hff);
    measure(2'h3, 1'b1, 8'hff);
    test_done();
  end
endmodule : testbench

`default_nettype wire
